/* design/mcs_pkg.sv */
package mcs_pkg;

  // Selection inputs forming the drive data set number
  localparam int unsigned MCS_SEL_W = 5;
  // Number of drive data sets and motor data sets supported
  localparam int unsigned MCS_DDS_N = 4;
  localparam int unsigned MCS_MDS_N = 4;
  // Width of a motor data set number and contactor status word
  localparam int unsigned MCS_MDS_W = 2;
  localparam int unsigned MCS_CSW_W = 8;
  // Width of a status bit index
  localparam int unsigned MCS_IDX_W = 3;
  // Width of thermal model number
  localparam int unsigned MCS_THM_W = 4;
  // Speed value width
  localparam int unsigned MCS_SPD_W = 16;
  // Changeover configuration field width
  localparam int unsigned MCS_CFG_W = 3;

  // Reset values and the changeover config code for config zero
  localparam logic [MCS_SEL_W-1:0] MCS_DDS_RST = 5'h00;
  localparam logic [MCS_CSW_W-1:0] MCS_CSW_RST = 8'h00;
  localparam logic [MCS_CFG_W-1:0] MCS_CFG_DRIVE_OWNS = 3'h0;

  // Sequencer states
  typedef enum logic [2:0] {
    MCS_IDLE      = 3'b000,
    MCS_INHIBIT   = 3'b001,
    MCS_OPEN_OLD  = 3'b010,
    MCS_ACTIVATE  = 3'b011,
    MCS_WAIT_OPEN = 3'b100,
    MCS_WAIT_CLOSE = 3'b101
  } mcs_state_t;

endpackage : mcs_pkg

/* design/mcs_speed_trigger.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Speed monitor: flags when actual speed is above the switchover threshold
module mcs_speed_trigger
  import mcs_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [MCS_SPD_W-1:0] i_speed,
  input wire logic [MCS_SPD_W-1:0] i_threshold,
  output logic o_speed_exceeded_flag
);

  logic flag_reg; // Registered comparison
  logic flag_next; // Next comparison value

  // Compare speed against configured threshold
  always_comb
  begin
    flag_next = (i_speed > i_threshold);
  end

  // Register so the selection bit is glitch free
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      flag_reg <= 1'b0;
    end
    else
    begin
      flag_reg <= flag_next;
    end
  end

  assign o_speed_exceeded_flag = flag_reg;

endmodule : mcs_speed_trigger

/* design/mcs_status_map.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Maps the active motor data set to a one-hot contactor status word
module mcs_status_map
  import mcs_pkg::*;
#(
  parameter int unsigned MDS_N = MCS_MDS_N
)
(
  input wire logic [MDS_N*MCS_IDX_W-1:0] i_status_bit_index,
  input wire logic [MCS_MDS_W-1:0] i_motor_data_set,
  input wire logic i_energise,
  output logic [MCS_CSW_W-1:0] o_contactor_status_word
);

  logic [MCS_IDX_W-1:0] idx; // Index of the bit for the selected set

  // Select the index belonging to the active motor data set
  always_comb
  begin
    idx = i_status_bit_index[i_motor_data_set*MCS_IDX_W +: MCS_IDX_W];
  end

  // One bit per output, set only when energising is allowed
  genvar b;
  generate
    for (b = 0; b < MCS_CSW_W; b = b + 1)
    begin : g_bit
      // Genvar cast to index width; indices past the word width never match
      assign o_contactor_status_word[b] = i_energise && (idx == MCS_IDX_W'(b));
    end
  endgenerate

endmodule : mcs_status_map

/* design/mcs_sequencer.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Binary data set number, input 0 is LSB
// - New request inhibits pulses at once
// - Clear contactor outputs, set switchover flag
// - Then make requested data set effective
// - Old contactor open confirmed, energise new
// - New contactor closed confirmed, end switchover
// - Per motor set index picks status bit
// - Motor number selects shared thermal model
// - Config zero: device owns contactors, parking bit; code drives contactors in every config, config zero only gates parking bit
// - Star/delta selection driven by speed monitor
// - One checkback input per motor set
// - Each status bit drives one contactor output
module mcs_sequencer
  import mcs_pkg::*;
#(
  parameter int unsigned DDS_N = MCS_DDS_N,
  parameter int unsigned MDS_N = MCS_MDS_N
)
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [MCS_SEL_W-1:0] i_data_set_select, // Bit 0 is data_set_select_bit0
  input wire logic i_star_delta_mode, // Bit 0 taken from the speed monitor
  input wire logic [MCS_SPD_W-1:0] i_actual_speed,
  input wire logic [MCS_SPD_W-1:0] i_switchover_speed_threshold,
  input wire logic [DDS_N*MCS_MDS_W-1:0] i_motor_set_mapping,
  input wire logic [MDS_N*MCS_IDX_W-1:0] i_status_bit_index,
  input wire logic [MDS_N*MCS_THM_W-1:0] i_thermal_model_number,
  input wire logic [MDS_N-1:0] i_contactor_checkback_input, // High = contactor closed
  input wire logic [MCS_CFG_W-1:0] i_changeover_config_bits,
  output logic [MCS_SEL_W-1:0] o_effective_data_set,
  output logic [MCS_CSW_W-1:0] o_contactor_status_readout,
  output logic o_switchover_in_progress,
  output logic o_pulse_inhibit,
  output logic o_parking_status_bit,
  output logic [MCS_THM_W-1:0] o_thermal_model_number,
  output logic o_speed_exceeded_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  mcs_state_t state_reg; // Sequencer state
  mcs_state_t state_next;
  logic [MCS_SEL_W-1:0] eff_reg; // Effective drive data set
  logic [MCS_SEL_W-1:0] eff_next;
  logic [MCS_MDS_W-1:0] old_mds_reg; // Motor set whose contactor is opening
  logic [MCS_MDS_W-1:0] old_mds_next;
  logic energise_reg; // Allows the status word onto the outputs
  logic energise_next;
  logic busy_reg; // Switchover in progress
  logic busy_next;
  logic inhibit_reg; // Pulse inhibit
  logic inhibit_next;
  logic parking_reg; // Parking status
  logic parking_next;
  logic [MCS_CSW_W-1:0] csw_reg; // Registered contactor status word
  logic [MCS_THM_W-1:0] thm_reg; // Registered thermal model number
  logic [MCS_THM_W-1:0] thm_next;
  logic [MCS_CSW_W-1:0] csw_comb; // Status word from the map
  logic speed_flag; // Speed monitor output
  logic [MCS_SEL_W-1:0] requested; // Requested drive data set number
  logic [MCS_SEL_W-1:0] dds_clip; // Effective set limited to a valid entry
  logic [MCS_MDS_W-1:0] mds_eff; // Motor set of the effective data set
  logic device_owns; // Config zero; only gates the parking status bit, contactors and inhibit are driven in every config

  ////////////////////////////////////////////////////////////////////////////
  // Speed monitor and contactor status map

  mcs_speed_trigger u_speed
  (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_speed(i_actual_speed),
    .i_threshold(i_switchover_speed_threshold),
    .o_speed_exceeded_flag(speed_flag)
  );

  mcs_status_map #(.MDS_N(MDS_N)) u_map
  (
    .i_status_bit_index(i_status_bit_index),
    .i_motor_data_set(mds_eff),
    .i_energise(energise_reg),
    .o_contactor_status_word(csw_comb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request decode

  // Weighted binary selection; star/delta replaces bit 0 by the speed flag
  always_comb
  begin
    requested = i_data_set_select;
    if (i_star_delta_mode)
    begin
      requested = {i_data_set_select[MCS_SEL_W-1:1], speed_flag};
    end
  end

  // Out of range numbers fall back to set 0 so the lookup stays in range
  always_comb
  begin
    dds_clip = (eff_reg < DDS_N[MCS_SEL_W-1:0]) ? eff_reg : MCS_DDS_RST;
    mds_eff = i_motor_set_mapping[dds_clip*MCS_MDS_W +: MCS_MDS_W];
    device_owns = (i_changeover_config_bits == MCS_CFG_DRIVE_OWNS);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state

  // One state per step; confirmations are level checks on the checkback
  always_comb
  begin
    state_next = state_reg;
    eff_next = eff_reg;
    old_mds_next = old_mds_reg;
    energise_next = energise_reg;
    busy_next = busy_reg;
    inhibit_next = inhibit_reg;
    // Sets sharing a motor number share the thermal model
    thm_next = i_thermal_model_number[mds_eff*MCS_THM_W +: MCS_THM_W];
    parking_next = device_owns && busy_reg;
    case (state_reg)
      MCS_IDLE:
      begin
        if (requested != eff_reg)
        begin
          inhibit_next = 1'b1;
          old_mds_next = mds_eff;
          state_next = MCS_INHIBIT;
        end
      end
      MCS_INHIBIT:
      begin
        // Contactors only move once pulses are already blocked
        energise_next = 1'b0;
        busy_next = 1'b1;
        state_next = MCS_OPEN_OLD;
      end
      MCS_OPEN_OLD:
      begin
        state_next = MCS_ACTIVATE;
      end
      MCS_ACTIVATE:
      begin
        // Latest request is taken; a change here just retargets
        eff_next = requested;
        state_next = MCS_WAIT_OPEN;
      end
      MCS_WAIT_OPEN:
      begin
        // Stays here forever if the old contactor never reports open
        if (!i_contactor_checkback_input[old_mds_reg])
        begin
          energise_next = 1'b1;
          state_next = MCS_WAIT_CLOSE;
        end
      end
      MCS_WAIT_CLOSE:
      begin
        if (i_contactor_checkback_input[mds_eff])
        begin
          busy_next = 1'b0;
          inhibit_next = 1'b0;
          state_next = MCS_IDLE;
        end
      end
      default:
      begin
        state_next = MCS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // All state cleared at reset except energise, which is set so outputs are energised from the effective set
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg <= MCS_IDLE;
      eff_reg <= MCS_DDS_RST;
      old_mds_reg <= '0;
      energise_reg <= 1'b1;
      busy_reg <= 1'b0;
      inhibit_reg <= 1'b0;
      parking_reg <= 1'b0;
      csw_reg <= MCS_CSW_RST;
      thm_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      eff_reg <= eff_next;
      old_mds_reg <= old_mds_next;
      energise_reg <= energise_next;
      busy_reg <= busy_next;
      inhibit_reg <= inhibit_next;
      parking_reg <= parking_next;
      csw_reg <= csw_comb;
      thm_reg <= thm_next;
    end
  end

  assign o_effective_data_set = eff_reg;
  assign o_contactor_status_readout = csw_reg;
  assign o_switchover_in_progress = busy_reg;
  assign o_pulse_inhibit = inhibit_reg;
  assign o_parking_status_bit = parking_reg;
  assign o_thermal_model_number = thm_reg;
  assign o_speed_exceeded_flag = speed_flag;

endmodule : mcs_sequencer

/* tb/mcs_sequencer_monitor.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Sequence checks at the sequencer ports
module mcs_sequencer_monitor
  import mcs_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [MCS_SEL_W-1:0] i_data_set_select,
  input wire logic i_star_delta_mode,
  input wire logic [MCS_SPD_W-1:0] i_actual_speed,
  input wire logic [MCS_SPD_W-1:0] i_switchover_speed_threshold,
  input wire logic [3:0] i_contactor_checkback_input,
  input wire logic [MCS_CFG_W-1:0] i_changeover_config_bits,
  input wire logic [MCS_SEL_W-1:0] o_effective_data_set,
  input wire logic [MCS_CSW_W-1:0] o_contactor_status_readout,
  input wire logic o_switchover_in_progress,
  input wire logic o_pulse_inhibit,
  input wire logic o_parking_status_bit,
  input wire logic o_speed_exceeded_flag
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // Idle: neither busy nor inhibited
  logic idle;
  assign idle = !o_switchover_in_progress && !o_pulse_inhibit;
  req_inhibit_a:
    assert property (idle && !i_star_delta_mode && i_data_set_select != o_effective_data_set |-> ##[1:2] o_pulse_inhibit)
    else $error("pulses not blocked on new request");
  busy_follows_a:
    assert property ($rose(o_pulse_inhibit) |=> $rose(o_switchover_in_progress))
    else $error("switchover flag late");
  word_cleared_a:
    assert property ($rose(o_switchover_in_progress) |=> o_contactor_status_readout == 8'h00)
    else $error("contactor word not cleared");
  set_applied_a:
    assert property ($rose(o_switchover_in_progress) |-> ##2 $changed(o_effective_data_set))
    else $error("effective set not updated");
  open_first_a:
    assert property (o_switchover_in_progress && $rose(|o_contactor_status_readout)
      |-> $past(i_contactor_checkback_input, 2) == 4'h0)
    else $error("new contactor energised before old opened");
  release_both_a:
    assert property ($fell(o_switchover_in_progress) |-> $fell(o_pulse_inhibit))
    else $error("inhibit and busy not released together");
  wait_hold_a:
    assert property (o_switchover_in_progress && i_contactor_checkback_input == 4'h0
      && o_contactor_status_readout != 8'h00 |=> o_switchover_in_progress && o_pulse_inhibit)
    else $error("wait state left without checkback");
  parking_flag_a:
    assert property (o_switchover_in_progress && i_changeover_config_bits == 3'h0 |=> o_parking_status_bit)
    else $error("parking bit missing");
  speed_flag_a:
    assert property ($past(i_rst_n) |-> o_speed_exceeded_flag
      == ($past(i_actual_speed) > $past(i_switchover_speed_threshold)))
    else $error("speed flag wrong");
endmodule : mcs_sequencer_monitor

bind mcs_sequencer mcs_sequencer_monitor mcs_sequencer_monitor_i (.i_core_clk, .i_rst_n, .i_data_set_select,
  .i_star_delta_mode, .i_actual_speed, .i_switchover_speed_threshold, .i_contactor_checkback_input,
  .i_changeover_config_bits, .o_effective_data_set, .o_contactor_status_readout, .o_switchover_in_progress,
  .o_pulse_inhibit, .o_parking_status_bit, .o_speed_exceeded_flag);

/* tb/mcs_contactor_model.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Four motor contactors; checkback follows the coil after a delay
// Motors are at rest and unbraked here, so no flying restart or brake hand-off
// is needed around a changeover
module mcs_contactor_model
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_word,
  input wire logic [11:0] i_idx,
  input wire logic i_stall,
  output logic [3:0] o_checkback
);
  logic [3:0] coil;
  logic [3:0] d1;
  logic [3:0] d2;
  // Each coil follows the status bit its index picks; stall freezes contacts (slow or stuck)
  always_comb for (int m = 0; m < 4; m++) coil[m] = i_word[i_idx[m*3+:3]];
  always @(posedge i_core_clk or negedge i_rst_n)
    if (!i_rst_n) {d1, d2, o_checkback} <= 12'h000;
    else if (!i_stall) {d1, d2, o_checkback} <= {coil, d1, d2};
endmodule : mcs_contactor_model

/* tb/testbench.sv */
`timescale 1ns/1ps

module testbench;
  import mcs_pkg::*;
  logic clk = 0, rst_n = 0, sd = 0, stall = 0, inh, busy, par, spf;
  logic [4:0] sel = 5'h00, eff;
  logic [15:0] spd = 16'h0000, thr = 16'h0064;
  logic [2:0] cfg = 3'h0;
  logic [3:0] cb, thm;
  logic [7:0] word;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  initial forever #5 clk = ~clk;
  mcs_sequencer mcs_sequencer_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_data_set_select(sel),
    .i_star_delta_mode(sd), .i_actual_speed(spd), .i_switchover_speed_threshold(thr),
    .i_motor_set_mapping(8'he4),
    .i_status_bit_index(12'h8d1), .i_thermal_model_number(16'h4321),
    .i_contactor_checkback_input(cb), .i_changeover_config_bits(cfg), .o_effective_data_set(eff),
    .o_contactor_status_readout(word), .o_switchover_in_progress(busy), .o_pulse_inhibit(inh),
    .o_parking_status_bit(par), .o_thermal_model_number(thm), .o_speed_exceeded_flag(spf));
  mcs_contactor_model mcs_contactor_model_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_word(word),
    .i_idx(12'h8d1), .i_stall(stall), .o_checkback(cb));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task end_sim;
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      end_sim;
    end
  end
  // One full switchover, stepped against the hand-over timing
  task automatic do_switch(input logic [4:0] s, input logic [15:0] v, input logic [4:0] e);
    int n;
    @(posedge clk);
    #1 sel = s;
    spd = v;
    n = 0;
    while (inh !== 1'b1 && n < 4)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk(inh, 1);
    @(posedge clk);
    #1 chk(busy, 1);
    @(posedge clk);
    #1 chk(word, 0);
    chk(par, cfg == 3'h0);
    @(posedge clk);
    #1 chk(eff, e);
    n = 0;
    while (busy !== 1'b0 && n < 300)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk(inh, 0);
    chk(word, 8'h01 << (e[1:0] + 1));
    chk(thm, e[1:0] + 1);
    $display("switch to %0d done", e);
  endtask : do_switch
  // Contactors frozen: sequence must sit in its wait state
  task t_stuck;
    stall = 1;
    @(posedge clk);
    #1 sel = 5'h00;
    repeat (40) @(posedge clk);
    #1 chk({busy, inh}, 2'b11);
    chk(eff, 5'h00);
    stall = 0;
    repeat (20) @(posedge clk);
    #1 chk(busy, 0);
    $display("stuck test done");
  endtask : t_stuck
  initial
  begin
    repeat (12) @(posedge clk);
    chk({eff, word, busy, inh}, 0);
    #1 rst_n = 1;
    repeat (10) @(posedge clk);
    #1 chk(word, 8'h02);
    // Speed held at zero until the last switch, which runs above the field weakening point
    do_switch(5'h02, 16'h0000, 5'h02);
    do_switch(5'h01, 16'h0000, 5'h01);
    do_switch(5'h03, 16'h0000, 5'h03);
    t_stuck;
    cfg = 3'h1;
    do_switch(5'h02, 16'h0000, 5'h02);
    cfg = 3'h0;
    sd = 1;
    do_switch(5'h00, 16'h0000, 5'h00);
    do_switch(5'h00, 16'h00c8, 5'h01);
    chk(spf, 1);
    end_sim;
  end
endmodule : testbench
